// [hdl/cmr_top.sv]
`timescale 1ns/1ps
`include "cmr_params.svh"
module cmr_top
    import cmr_pkg::*;
(
    input  wire logic        I_CLK,
    input  wire logic        I_SYS_RST,
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic [7:0]  i_strap,
    input  wire logic        i_track_input_ok,
    input  wire logic        i_softstart_active,
    output logic      [15:0] o_rdata,
    output logic             o_rvalid,
    output logic      [2:0]  o_power_good_delay_sel,
    output logic      [2:0]  o_power_on_delay_sel,
    output logic             o_reference_source_ext,
    output logic             o_ramp_source_ext,
    output logic      [1:0]  o_softstart_time_sel,
    output logic             o_uv_fault_response,
    output logic             o_forced_continuous_mode,
    output logic             o_ramp_injection_en,
    output logic      [1:0]  o_ramp_resistor_sel,
    output logic      [2:0]  o_switch_freq_sel,
    output logic             o_loop_offset_auto,
    output logic      [1:0]  o_loop_offset_trim,
    output logic      [2:0]  o_bias_undervolt_level,
    output logic             o_pg_window_sel,
    output logic             o_aux_bit_output,
    output logic      [3:0]  o_track_target_sel,
    output logic             o_switch_allow
);
    cmr_init_type state_r;
    cmr_init_type state_nxt;
    logic         load;
    logic [7:0]   strap_q;
    logic [7:0]   r_delay;
    logic [7:0]   r_strap;
    logic [7:0]   r_loop;
    logic [7:0]   r_offset;
    logic [7:0]   r_bias;
    logic [7:0]   r_track;
    logic [7:0]   strap_load;
    logic [7:0]   loop_load;
    logic         wr_delay;
    logic         wr_strap;
    logic         wr_loop;
    logic         wr_offset;
    logic         wr_bias;
    logic         wr_track;
    logic [15:0]  rd_mux;
    logic [15:0]  ident;
    logic         track_ok;
    logic         conduct_forced_continuous_mode;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_strap
            cmr_sync u_sync (
                .i_clk   (I_CLK),
                .i_rst   (I_SYS_RST),
                .i_async (i_strap[gi]),
                .o_level (strap_q[gi])
            );
        end
    endgenerate

    cmr_sync u_trk (
        .i_clk   (I_CLK),
        .i_rst   (I_SYS_RST),
        .i_async (i_track_input_ok),
        .o_level (track_ok)
    );

    // Straps are loaded under reset and in the RESET and LOAD states; the last capture is in LOAD, after the synchronisers settle.
    always_comb begin
        case (state_r)
            CMR_INIT_type_RESET: state_nxt = CMR_INIT_type_LOAD;
            CMR_INIT_type_LOAD:  state_nxt = CMR_INIT_type_RUN;
            CMR_INIT_type_RUN:   state_nxt = CMR_INIT_type_RUN;
            default:             state_nxt = CMR_INIT_type_RESET;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            state_r <= CMR_INIT_type_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign load = I_SYS_RST | (state_r != CMR_INIT_type_RUN);
    assign strap_load = {strap_q[7:6], 1'h0, `CMR_RST_FORCE_SKIP, strap_q[3:0]};
    assign loop_load = {strap_q[4], 1'h0, strap_q[1:0], 1'h0, `CMR_RST_FREQ};

    assign wr_delay  = i_wr_en & (i_addr == `CMR_ADDR_DELAY);
    assign wr_strap  = i_wr_en & (i_addr == `CMR_ADDR_STRAP);
    assign wr_loop   = i_wr_en & (i_addr == `CMR_ADDR_LOOP);
    assign wr_offset = i_wr_en & (i_addr == `CMR_ADDR_OFFSET);
    assign wr_bias   = i_wr_en & (i_addr == `CMR_ADDR_BIAS_UV);
    assign wr_track  = i_wr_en & (i_addr == `CMR_ADDR_TRACK);

    cmr_wreg u_delay (
        .i_clk      (I_CLK),
        .i_load     (I_SYS_RST),
        .i_load_val (`CMR_RST_DELAY),
        .i_wr       (wr_delay),
        .i_wdata    (i_wdata[7:0]),
        .i_mask     (`CMR_MASK_DELAY),
        .o_q        (r_delay)
    );
    cmr_wreg u_strap (
        .i_clk      (I_CLK),
        .i_load     (load),
        .i_load_val (strap_load),
        .i_wr       (wr_strap),
        .i_wdata    (i_wdata[7:0]),
        .i_mask     (`CMR_MASK_STRAP),
        .o_q        (r_strap)
    );
    cmr_wreg u_loop (
        .i_clk      (I_CLK),
        .i_load     (load),
        .i_load_val (loop_load),
        .i_wr       (wr_loop),
        .i_wdata    (i_wdata[7:0]),
        .i_mask     (`CMR_MASK_LOOP),
        .o_q        (r_loop)
    );
    cmr_wreg u_offset (
        .i_clk      (I_CLK),
        .i_load     (I_SYS_RST),
        .i_load_val (`CMR_RST_OFFSET),
        .i_wr       (wr_offset),
        .i_wdata    (i_wdata[7:0]),
        .i_mask     (`CMR_MASK_OFFSET),
        .o_q        (r_offset)
    );
    cmr_wreg u_bias (
        .i_clk      (I_CLK),
        .i_load     (I_SYS_RST),
        .i_load_val (`CMR_RST_BIAS_UV),
        .i_wr       (wr_bias),
        .i_wdata    (i_wdata[7:0]),
        .i_mask     (`CMR_MASK_BIAS_UV),
        .o_q        (r_bias)
    );
    cmr_wreg u_track (
        .i_clk      (I_CLK),
        .i_load     (I_SYS_RST),
        .i_load_val (`CMR_RST_TRACK),
        .i_wr       (wr_track),
        .i_wdata    (i_wdata[7:0]),
        .i_mask     (`CMR_MASK_TRACK),
        .o_q        (r_track)
    );

    assign ident = {`CMR_DEVICE_ID, `CMR_REVISION};

    always_comb begin
        case (i_addr)
            `CMR_ADDR_DELAY:   rd_mux = {8'h00, r_delay};
            `CMR_ADDR_STRAP:   rd_mux = {8'h00, r_strap};
            `CMR_ADDR_LOOP:    rd_mux = {8'h00, r_loop};
            `CMR_ADDR_OFFSET:  rd_mux = {8'h00, r_offset};
            `CMR_ADDR_BIAS_UV: rd_mux = {8'h00, r_bias};
            `CMR_ADDR_TRACK:   rd_mux = {8'h00, r_track};
            `CMR_ADDR_IDENT:   rd_mux = ident;
            default:           rd_mux = 16'h0000;
        endcase
    end

    assign conduct_forced_continuous_mode = r_strap[0] & ~(r_strap[4] & i_softstart_active);

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            o_rdata  <= 16'h0000;
            o_rvalid <= 1'h0;
        end else begin
            o_rdata  <= i_rd_en ? rd_mux : 16'h0000;
            o_rvalid <= i_rd_en;
        end
    end

    // Outputs are a register copy, so field changes appear one cycle after a write.
    always_ff @(posedge I_CLK) begin
        o_power_good_delay_sel   <= r_delay[5:3];
        o_power_on_delay_sel     <= r_delay[2:0];
        o_reference_source_ext   <= r_strap[7];
        o_ramp_source_ext        <= r_strap[6];
        o_softstart_time_sel     <= r_strap[3:2];
        o_uv_fault_response      <= r_strap[1];
        o_forced_continuous_mode <= conduct_forced_continuous_mode;
        o_ramp_injection_en      <= r_loop[7];
        o_ramp_resistor_sel      <= r_loop[5:4];
        o_switch_freq_sel        <= r_loop[2:0];
        o_loop_offset_auto       <= r_offset[`CMR_OFFSET_AUTO_BIT];
        o_loop_offset_trim       <= r_offset[`CMR_OFFSET_AUTO_BIT] ? 2'h0 : r_offset[6:5];
        o_bias_undervolt_level   <= r_bias[2:0];
        o_pg_window_sel          <= r_track[7];
        o_aux_bit_output         <= r_track[6];
        o_track_target_sel       <= r_track[3:0];
        o_switch_allow           <= r_track[`CMR_TRACK_GATE_BIT] | track_ok;
    end
endmodule

// [hdl/cmr_params.svh]
`ifndef CMR_PARAMS_SVH
`define CMR_PARAMS_SVH
`define CMR_ADDR_DELAY      8'hd1
`define CMR_ADDR_STRAP      8'hd2
`define CMR_ADDR_LOOP       8'hd3
`define CMR_ADDR_OFFSET     8'hd4
`define CMR_ADDR_BIAS_UV    8'hd6
`define CMR_ADDR_TRACK      8'hd7
`define CMR_ADDR_IDENT      8'hfc
`define CMR_MASK_DELAY      8'h3f
`define CMR_MASK_STRAP      8'hdf
`define CMR_MASK_LOOP       8'hb7
`define CMR_MASK_OFFSET     8'he0
`define CMR_MASK_BIAS_UV    8'h07
`define CMR_MASK_TRACK      8'hdf
`define CMR_RST_DELAY       8'h12
`define CMR_RST_FORCE_SKIP  1'h1
`define CMR_RST_FREQ        3'h3
`define CMR_RST_OFFSET      8'h80
`define CMR_RST_BIAS_UV     8'h05
`define CMR_RST_TRACK       8'h8f
`define CMR_DEVICE_ID       12'h5a5
`define CMR_REVISION        4'h0
`define CMR_OFFSET_AUTO_BIT 7
`define CMR_TRACK_GATE_BIT  4
`endif

// [hdl/cmr_pkg.sv]
package cmr_pkg;
    typedef enum logic [1:0] {
        CMR_INIT_type_RESET = 2'h0,
        CMR_INIT_type_LOAD  = 2'h1,
        CMR_INIT_type_RUN   = 2'h3
    } cmr_init_type;
endpackage

// [hdl/cmr_sync.sv]
`timescale 1ns/1ps
module cmr_sync (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    // The chain keeps sampling under reset, so the strap level is settled
    // by the time the load window after reset captures it.
    always_ff @(posedge i_clk) begin
        s1_r <= i_async;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
            o_level <= s3_r;
        end
    end
endmodule

// [hdl/cmr_wreg.sv]
`timescale 1ns/1ps
`include "cmr_params.svh"
module cmr_wreg (
    input  wire logic       i_clk,
    input  wire logic       i_load,
    input  wire logic [7:0] i_load_val,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_wdata,
    input  wire logic [7:0] i_mask,
    output logic      [7:0] o_q
);
    logic [7:0] q_nxt;
    assign q_nxt = i_load ? (i_load_val & i_mask) :
                   i_wr ? ((i_wdata & i_mask) | (o_q & ~i_mask)) : o_q;
    always_ff @(posedge i_clk) begin
        o_q <= q_nxt & i_mask;
    end
endmodule

// [sim/cmr_host.sv]
`timescale 1ns/1ps
module cmr_host (
    input  wire logic        I_CLK,
    input  wire logic [15:0] o_rdata,
    output logic             i_wr_en,
    output logic             i_rd_en,
    output logic      [7:0]  i_addr,
    output logic      [15:0] i_wdata
);
    initial begin
        i_wr_en = 1'h0;
        i_rd_en = 1'h0;
        i_addr = 8'h00;
        i_wdata = 16'h0000;
    end
    // After an access the address, and after a write the write data, show the inverse of their last value so stale data cannot pass.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge I_CLK);
        #1;
        i_wr_en = 1'h1;
        i_addr = a;
        i_wdata = d;
        @(posedge I_CLK);
        #1;
        i_wr_en = 1'h0;
        i_addr = ~a;
        i_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge I_CLK);
        #1;
        i_rd_en = 1'h1;
        i_addr = a;
        @(posedge I_CLK);
        #1;
        i_rd_en = 1'h0;
        i_addr = ~a;
        d = o_rdata;
    endtask
endmodule

// [sim/cmr_top_monitor.sv]
`timescale 1ns/1ps
`include "cmr_params.svh"
module cmr_monitor (
    input wire logic        I_CLK,
    input wire logic        I_SYS_RST,
    input wire logic        i_wr_en,
    input wire logic        i_rd_en,
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic [2:0]  o_power_good_delay_sel,
    input wire logic [2:0]  o_power_on_delay_sel,
    input wire logic        o_ramp_injection_en,
    input wire logic [1:0]  o_ramp_resistor_sel,
    input wire logic [2:0]  o_switch_freq_sel,
    input wire logic        o_loop_offset_auto,
    input wire logic [1:0]  o_loop_offset_trim,
    input wire logic        o_pg_window_sel,
    input wire logic        o_aux_bit_output,
    input wire logic [3:0]  o_track_target_sel
);
    logic [15:0] wd1_r;
    logic [15:0] wd2_r;
    logic        hit;
    assign hit = i_addr inside {8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd6, 8'hd7, 8'hfc};
    always_ff @(posedge I_CLK) begin
        wd1_r <= i_wdata;
        wd2_r <= wd1_r;
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    a_read_answer: assert property (i_rd_en |=> o_rvalid)
        else $error("read not answered");
    a_idle_quiet: assert property (!i_rd_en |=> !o_rvalid && o_rdata == 16'h0)
        else $error("read data without read");
    a_ident_word: assert property (i_rd_en && i_addr == 8'hfc |=>
        o_rdata == {`CMR_DEVICE_ID, `CMR_REVISION}) else $error("identity word wrong");
    a_unmapped_zero: assert property (i_rd_en && !hit |=> o_rdata == 16'h0)
        else $error("unmapped read not zero");
    a_offset_reserved: assert property (i_rd_en && i_addr == 8'hd4 |=>
        o_rdata[15:8] == 8'h0 && o_rdata[4:0] == 5'h0) else $error("offset reserved bits set");
    a_delay_follow: assert property (i_wr_en && i_addr == 8'hd1 ##1
        !(i_wr_en && i_addr == 8'hd1) |=> {o_power_good_delay_sel, o_power_on_delay_sel}
        == wd2_r[5:0]) else $error("delay selects not updated");
    a_loop_follow: assert property (i_wr_en && i_addr == 8'hd3 ##1
        !(i_wr_en && i_addr == 8'hd3) |=> {o_ramp_injection_en, o_ramp_resistor_sel,
        o_switch_freq_sel} == {wd2_r[7], wd2_r[5:4], wd2_r[2:0]}) else $error("loop fields wrong");
    a_track_follow: assert property (i_wr_en && i_addr == 8'hd7 ##1
        !(i_wr_en && i_addr == 8'hd7) |=> {o_pg_window_sel, o_aux_bit_output,
        o_track_target_sel} == {wd2_r[7:6], wd2_r[3:0]}) else $error("tracking fields wrong");
    a_trim_auto: assert property (o_loop_offset_auto |-> o_loop_offset_trim == 2'h0)
        else $error("trim active in auto mode");
endmodule
bind cmr_top cmr_monitor u_mon (.*);

// [sim/testbench.sv]
`timescale 1ns/1ps
`include "cmr_params.svh"
module testbench;
    logic I_CLK, I_SYS_RST, i_wr_en, i_rd_en, i_track_input_ok, i_softstart_active, o_rvalid;
    logic o_reference_source_ext, o_ramp_source_ext, o_uv_fault_response, o_switch_allow;
    logic o_forced_continuous_mode, o_ramp_injection_en, o_loop_offset_auto;
    logic o_pg_window_sel, o_aux_bit_output;
    logic [7:0]  i_addr, i_strap;
    logic [15:0] i_wdata, o_rdata;
    logic [3:0]  o_track_target_sel;
    logic [2:0]  o_power_good_delay_sel, o_power_on_delay_sel, o_switch_freq_sel;
    logic [2:0]  o_bias_undervolt_level;
    logic [1:0]  o_softstart_time_sel, o_ramp_resistor_sel, o_loop_offset_trim;
    int          err_count, tests_run, cyc;
    logic [7:0]  adr [9] = '{8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd6, 8'hd7, 8'hfc, 8'hd5, 8'hd0};
    logic [15:0] rst_v [9] = '{16'h12, 16'hd9, 16'h13, 16'h80, 16'h05, 16'h8f,
                               {`CMR_DEVICE_ID, `CMR_REVISION}, 16'h0, 16'h0};
    logic [15:0] msk_v [9] = '{16'h3f, 16'hdf, 16'hb7, 16'he0, 16'h07, 16'hdf,
                               {`CMR_DEVICE_ID, `CMR_REVISION}, 16'h0, 16'h0};
    wire  [15:0] others = {1'h0, o_power_good_delay_sel, o_power_on_delay_sel,
        o_bias_undervolt_level, o_pg_window_sel, o_aux_bit_output, o_track_target_sel};
    wire  [15:0] fields = {4'h0, o_reference_source_ext, o_ramp_source_ext, o_softstart_time_sel,
        o_uv_fault_response, o_forced_continuous_mode, o_ramp_injection_en,
        o_ramp_resistor_sel, o_switch_freq_sel};
    cmr_top uut (.*);
    cmr_host host (.*);
    initial begin
        I_CLK = 1'b0;
        forever #20 I_CLK = ~I_CLK;
    end
    task automatic end_of_test;
        if (err_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        host.rd(a, d);
        chk("rdata", e, d);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge I_CLK);
        #1;
    endtask
    always @(posedge I_CLK) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        I_SYS_RST = 1'b1;
        i_strap = 8'hc9;
        i_track_input_ok = 1'b0;
        i_softstart_active = 1'b0;
        wt(3);
        I_SYS_RST = 1'b0;
        wt(6);
        for (int i = 0; i < 9; i++) rc(adr[i], rst_v[i]);
        chk("straps", 16'h0e4b, fields);
        chk("others", 16'h256f, others);
        for (int i = 0; i < 9; i++) begin
            host.wr(adr[i], 16'hffff);
            rc(adr[i], msk_v[i]);
        end
        wt(3);
        chk("fields", 16'h0fff, fields);
        chk("others", 16'h7fff, others);
        for (int i = 0; i < 9; i++) begin
            host.wr(adr[i], 16'h0000);
            rc(adr[i], (i == 6) ? msk_v[6] : 16'h0);
        end
        wt(3);
        chk("fields", 16'h0, fields);
        chk("others", 16'h0, others);
        host.wr(8'hd4, 16'h0060);
        wt(3);
        chk("trim", 16'h3, {14'h0, o_loop_offset_trim});
        host.wr(8'hd4, 16'h00e0);
        wt(3);
        chk("offset", 16'h4, {13'h0, o_loop_offset_auto, o_loop_offset_trim});
        host.wr(8'hd2, 16'h0011);
        i_softstart_active = 1'b1;
        wt(3);
        chk("forced_continuous_mode", 16'h0, {15'h0, o_forced_continuous_mode});
        i_softstart_active = 1'b0;
        wt(3);
        chk("forced_continuous_mode", 16'h1, {15'h0, o_forced_continuous_mode});
        host.wr(8'hd2, 16'h0001);
        i_softstart_active = 1'b1;
        wt(3);
        chk("forced_continuous_mode", 16'h1, {15'h0, o_forced_continuous_mode});
        i_softstart_active = 1'b0;
        chk("allow", 16'h0, {15'h0, o_switch_allow});
        i_track_input_ok = 1'b1;
        wt(6);
        chk("allow", 16'h1, {15'h0, o_switch_allow});
        i_track_input_ok = 1'b0;
        host.wr(8'hd7, 16'h0010);
        wt(6);
        chk("allow", 16'h1, {15'h0, o_switch_allow});
        I_SYS_RST = 1'b1;
        wt(3);
        I_SYS_RST = 1'b0;
        wt(6);
        rc(8'hd2, 16'hd9);
        rc(8'hd3, 16'h13);
        chk("straps", 16'h0e4b, fields);
        chk("others", 16'h256f, others);
        end_of_test();
    end
endmodule
